/* File: cmpb_bank.sv */
// Comparator control and status bank with an AHB-Lite register slave.
// Assumes comparator results arrive asynchronously from the analog
// side and idle_mode comes from the power controller on hclk.
//
// What this block does
// R01 - Channel select routes inverting input B/C/D/bandgap
// R02 - First interrupt fires on any transition
// R03 - Later interrupts follow configured event polarity
// R04 - Idle stop bit masks interrupts during idle
// R05 - Idle stop clear keeps interrupts during idle
// R06 - Status bits 10:8 mirror comparator event flags
// R07 - Status bits 2:0 mirror comparator outputs
// R08 - Event and output status are hardware only
// R09 - Unimplemented bits always read as zero
// R10 - Comparators 2 and 3 only in large variant
// R11 - Status resets to zero, reads have no effects
`timescale 1ns/1ps
`default_nettype none

module cmpb_bank
    import cmpb_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic hclk, // Bus clock, 10 MHz.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // High for write.
    input wire logic [2:0] hsize, // Transfer size, word only.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic [31:0] hrdata, // Read data.
    output logic hreadyout, // Slave ready.
    output logic hresp, // Always OKAY.
    input wire logic [NUM_COMP-1:0] comp_result_raw, // Analog outputs.
    input wire logic idle_mode, // Core is in idle.
    output cmpb_route_t [NUM_COMP-1:0] inverting_route, // Mux steering.
    output logic [NUM_COMP-1:0] comp_enable, // Analog enable.
    output logic irq // Level interrupt.
);

    // Bus phase tracking.
    logic rd_q;
    logic wr_q;
    logic rd_done_q;
    logic [OFS_W-1:0] addr_q;
    logic [31:0] hrdata_q;
    logic addr_phase;

    // Register state.
    logic idle_stop_q;
    logic [NUM_COMP-1:0] irq_stat_q;
    logic [NUM_COMP-1:0] irq_en_q;
    cmpb_ctrl_t [NUM_COMP-1:0] ctrl;
    logic [NUM_COMP-1:0] hit;
    logic [NUM_COMP-1:0] present;
    logic [15:0] stat_word;
    logic [31:0] rd_mux;
    logic irq_gate;

    // Write strobes per register.
    logic wr_stat;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic [NUM_COMP-1:0] wr_ctrl;

    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign hresp = HRESP_OKAY;

    // Capture the address phase; only taken while the bus is ready.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= '0;
        end else if (hready) begin
            rd_q <= addr_phase && !hwrite;
            wr_q <= addr_phase && hwrite;
            addr_q <= haddr[OFS_W-1:0];
        end
    end

    // Reads take one wait state so that hrdata comes from a flop and
    // also sees a write finished in the cycle before.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= rd_q && !rd_done_q;
        end
    end

    assign hreadyout = !(rd_q && !rd_done_q);

    // Read data register, loaded in the wait cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (rd_q && !rd_done_q) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata = hrdata_q;

    // Write strobes fire in a zero-wait data phase.
    always_comb begin
        wr_stat = wr_q && hready && (addr_q == OFS_STAT);
        wr_irq_en = wr_q && hready && (addr_q == OFS_IRQ_EN);
        wr_irq_clr = wr_q && hready && (addr_q == OFS_IRQ_CLR);
        wr_ctrl[0] = wr_q && hready && (addr_q == OFS_CTRL1);
        wr_ctrl[1] = wr_q && hready && (addr_q == OFS_CTRL2);
        wr_ctrl[2] = wr_q && hready && (addr_q == OFS_CTRL3);
    end

    // Idle stop control, the only writable status bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_stop_q <= STAT_RESET[STAT_IDLE_BIT]; // see R11
        end else if (wr_stat) begin
            idle_stop_q <= hwdata[STAT_IDLE_BIT]; // see R08
        end
    end

    // Comparator slots; small variants build only the first one.
    for (genvar i = 0; i < NUM_COMP; i++) begin : g_comp
        if (i == 0 || LARGE_VARIANT) begin : g_on // see R10
            logic [1:0] sync_q;
            logic prev_q;
            logic first_done_q;
            logic en_q;
            logic evt_q;
            cmpb_pol_t pol_q;
            logic [1:0] sel_q;
            logic rise;
            logic fall;
            logic match;
            logic pol_change;

            // Two flops before the analog result is used.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync_q <= '0;
                    prev_q <= 1'b0;
                end else begin
                    sync_q <= {sync_q[0], comp_result_raw[i]};
                    prev_q <= sync_q[1];
                end
            end

            assign rise = sync_q[1] && !prev_q;
            assign fall = !sync_q[1] && prev_q;
            assign pol_change = wr_ctrl[i] &&
                (hwdata[CTL_POL_LSB+:2] != pol_q);

            // Polarity match for every event after the first.
            always_comb begin
                case (pol_q)
                    POL_RISE: match = rise; // see R03
                    POL_FALL: match = fall; // see R03
                    POL_ANY: match = rise || fall; // see R03
                    default: match = 1'b0;
                endcase
            end

            // Before the first interrupt any edge counts.
            assign hit[i] = en_q && (pol_q != POL_NONE) &&
                (first_done_q ? match : (rise || fall)); // see R02

            // Control fields written by software.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    en_q <= 1'b0;
                    pol_q <= POL_NONE;
                    sel_q <= SEL_PIN_B;
                end else if (wr_ctrl[i]) begin
                    en_q <= hwdata[CTL_EN_BIT];
                    pol_q <= cmpb_pol_t'(hwdata[CTL_POL_LSB+:2]);
                    sel_q <= hwdata[CTL_SEL_LSB+:2];
                end
            end

            // Arms the any-edge first interrupt again after a new
            // polarity or a disable.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    first_done_q <= 1'b0;
                end else if (pol_change || !en_q) begin
                    first_done_q <= 1'b0; // see R02
                end else if (hit[i]) begin
                    first_done_q <= 1'b1; // see R03
                end
            end

            // Event flag: set by hardware wins over a software clear.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    evt_q <= 1'b0;
                end else if (hit[i]) begin
                    evt_q <= 1'b1;
                end else if (wr_ctrl[i] && !hwdata[CTL_EVT_BIT]) begin
                    evt_q <= 1'b0;
                end
            end

            always_comb begin
                ctrl[i].enable = en_q;
                ctrl[i].event_flag = evt_q;
                ctrl[i].result = en_q && sync_q[1];
                ctrl[i].event_polarity_select = pol_q;
                ctrl[i].inverting_input_select = sel_q;
            end

            // Decode the channel select into a one-hot analog route.
            always_comb begin
                inverting_route[i] = '0;
                case (sel_q)
                    SEL_BGBUF: inverting_route[i].buffered_bandgap_ref_one = 1'b1; // see R01
                    SEL_PIN_D: inverting_route[i].comp_input_pin_d = 1'b1; // see R01
                    SEL_PIN_C: inverting_route[i].comp_input_pin_c = 1'b1; // see R01
                    default: inverting_route[i].comp_input_pin_b = 1'b1; // see R01
                endcase
            end

            assign comp_enable[i] = en_q;
            assign present[i] = 1'b1;
        end else begin : g_off
            // Absent slots read as zero and never raise an event.
            assign ctrl[i] = '0; // see R10
            assign hit[i] = 1'b0;
            assign inverting_route[i] = '0;
            assign comp_enable[i] = 1'b0;
            assign present[i] = 1'b0;
        end
    end

    // Interrupt status: sticky, set wins over a write-one clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= IRQ_RESET;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ?
                hwdata[NUM_COMP-1:0] : '0)) | hit;
        end
    end

    // Interrupt enable register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_q <= IRQ_RESET;
        end else if (wr_irq_en) begin
            irq_en_q <= hwdata[NUM_COMP-1:0] & present;
        end
    end

    // Comparators keep running in idle; only the request is held back
    // so no event is lost, it fires once idle ends.
    assign irq_gate = !(idle_stop_q && idle_mode); // see R04 see R05
    assign irq = irq_gate && |(irq_stat_q & irq_en_q);

    // Module status word built from live hardware state.
    always_comb begin
        stat_word = '0; // see R09
        stat_word[STAT_IDLE_BIT] = idle_stop_q;
        for (int k = 0; k < NUM_COMP; k++) begin
            stat_word[STAT_EVT_LSB+k] = ctrl[k].event_flag; // see R06
            stat_word[STAT_RES_LSB+k] = ctrl[k].result; // see R07
        end
    end

    // Read multiplexer; reads only select, they clear nothing.
    always_comb begin
        rd_mux = '0; // see R11
        case (addr_q)
            OFS_CTRL1, OFS_CTRL2, OFS_CTRL3: begin
                for (int k = 0; k < NUM_COMP; k++) begin
                    if (addr_q == OFS_W'(k * 4)) begin
                        rd_mux[CTL_EN_BIT] = ctrl[k].enable;
                        rd_mux[CTL_EVT_BIT] = ctrl[k].event_flag;
                        rd_mux[CTL_RES_BIT] = ctrl[k].result;
                        rd_mux[CTL_POL_LSB+:2] = ctrl[k].event_polarity_select;
                        rd_mux[CTL_SEL_LSB+:2] = ctrl[k].inverting_input_select;
                    end
                end
            end
            OFS_STAT: rd_mux[15:0] = stat_word;
            OFS_IRQ_STAT: rd_mux[NUM_COMP-1:0] = irq_stat_q;
            OFS_IRQ_EN: rd_mux[NUM_COMP-1:0] = irq_en_q;
            default: rd_mux = '0;
        endcase
    end

endmodule

`default_nettype wire

/* File: cmpb_pkg.sv */
// Package for the comparator control and status bank.
// Assumes a single hclk domain and AHB-Lite register access.
package cmpb_pkg;

    // Number of comparator slots in the largest variant.
    localparam int unsigned NUM_COMP = 3;

    // Register byte offsets, decoded from haddr[7:0].
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_CTRL3 = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
    localparam int unsigned OFS_W = 8;

    // Comparator control register field positions.
    localparam int unsigned CTL_EN_BIT = 15;
    localparam int unsigned CTL_EVT_BIT = 9;
    localparam int unsigned CTL_RES_BIT = 8;
    localparam int unsigned CTL_POL_LSB = 6;
    localparam int unsigned CTL_SEL_LSB = 0;

    // Module status register field positions.
    localparam int unsigned STAT_IDLE_BIT = 15;
    localparam int unsigned STAT_EVT_LSB = 8;
    localparam int unsigned STAT_RES_LSB = 0;

    // Reset values.
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [NUM_COMP-1:0] IRQ_RESET = 3'h0;

    // AHB encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Inverting input routing codes.
    localparam logic [1:0] SEL_PIN_B = 2'h0;
    localparam logic [1:0] SEL_PIN_C = 2'h1;
    localparam logic [1:0] SEL_PIN_D = 2'h2;
    localparam logic [1:0] SEL_BGBUF = 2'h3;

    // Event polarity modes.
    typedef enum logic [1:0] {
        POL_NONE = 2'h0,
        POL_RISE = 2'h1,
        POL_FALL = 2'h2,
        POL_ANY = 2'h3
    } cmpb_pol_t;

    // One comparator's software-visible control fields.
    typedef struct packed {
        logic enable;
        logic event_flag;
        logic result;
        cmpb_pol_t event_polarity_select;
        logic [1:0] inverting_input_select;
    } cmpb_ctrl_t;

    // One-hot route of the inverting input to the analog mux.
    typedef struct packed {
        logic buffered_bandgap_ref_one;
        logic comp_input_pin_d;
        logic comp_input_pin_c;
        logic comp_input_pin_b;
    } cmpb_route_t;

endpackage

/* File: cmpb_bank_properties.sv */
// Port-level checks for the comparator bank.
// Assumes one hclk domain and one bus master with hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module cmpb_bank_properties
    import cmpb_pkg::*;
(
    input wire logic hclk, // Clock.
    input wire logic hresetn, // Reset.
    input wire logic hsel, // Select.
    input wire logic [31:0] haddr, // Address.
    input wire logic [1:0] htrans, // Type.
    input wire logic hwrite, // Write.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Ready in.
    input wire logic [31:0] hrdata, // Read data.
    input wire logic hreadyout, // Ready out.
    input wire logic idle_mode, // Idle.
    input wire cmpb_route_t [NUM_COMP-1:0] inverting_route, // Route.
    input wire logic [NUM_COMP-1:0] comp_enable, // Enables.
    input wire logic irq // Interrupt.
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && hready && htrans == HTRANS_NONSEQ;
    logic stat_wr_q;
    logic idle_stop_q;
    // Shadow of the idle stop bit, since the register itself is not a port.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_wr_q <= 1'b0;
            idle_stop_q <= 1'b0;
        end else begin
            if (hready) begin
                stat_wr_q <= take && hwrite && haddr[7:0] == OFS_STAT;
            end
            if (stat_wr_q && hreadyout) begin
                idle_stop_q <= hwdata[STAT_IDLE_BIT];
            end
        end
    end
    chk_route_onehot: assert property ($onehot(inverting_route[0]))
        else $error("inverting route is not one-hot");
    chk_idle_stop_mask: assert property (idle_stop_q && idle_mode |-> !irq)
        else $error("irq raised while idle stop holds");
    chk_idle_keeps_irq: assert property ($rose(idle_mode) && !idle_stop_q |->
        irq == $past(irq))
        else $error("irq changed on idle entry");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && comp_enable == '0)
        else $error("outputs not quiet after reset");
    chk_stat_reserved: assert property (take && !hwrite && haddr[7:0] == OFS_STAT |->
        ##2 hrdata[14:11] == 4'h0 && hrdata[7:3] == 5'h0)
        else $error("status reserved bits not zero");
    chk_ctrl_reserved: assert property (take && !hwrite && haddr[7:0] == OFS_CTRL1 |->
        ##2 hrdata[2] == 1'b0)
        else $error("control bit 2 not zero");
    chk_write_nowait: assert property (take && hwrite |=> hreadyout) // bus timing
        else $error("write data phase stalled");
    chk_read_onewait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) // bus timing
        else $error("read wait state wrong");
endmodule
bind cmpb_bank cmpb_bank_properties u_cmpb_bank_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .idle_mode(idle_mode), .inverting_route(inverting_route),
    .comp_enable(comp_enable), .irq(irq));
`default_nettype wire

/* File: cmpb_tb.sv */
// Self-checking testbench for the comparator bank.
// Assumes the bank is the only slave, so hready follows hreadyout.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cmpb_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, idle_mode, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, comp_result_raw, comp_enable;
    cmpb_route_t [NUM_COMP-1:0] inverting_route;
    int errors, num_checks, cycles;
    assign hready = hreadyout;
    cmpb_bank u_cmpb_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .comp_result_raw(comp_result_raw), .idle_mode(idle_mode),
        .inverting_route(inverting_route), .comp_enable(comp_enable), .irq(irq));
    // Clock and a cycle ceiling; the tests need under two hundred cycles.
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Ready is looked at on the falling edge, where it is settled until the rise.
    task wait_rdy();
        logic ok;
        do begin
            @(negedge hclk);
            ok = hready;
            rd = hrdata;
            @(posedge hclk);
        end while (ok !== 1'b1);
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(n, rd, e);
    endtask
    task irqchk(input logic e);
        @(negedge hclk);
        check("irq", {31'h0, irq}, {31'h0, e});
        @(posedge hclk);
    endtask
    // The synchroniser and edge detect need about three edges; six is safe.
    task rawk(input int k, input logic v);
        comp_result_raw[k] <= v;
        repeat (6) @(posedge hclk);
    endtask
    task raw(input logic v);
        rawk(0, v);
    endtask
    task clr();
        xfer(1'b1, OFS_CTRL1, 32'h8040);
        xfer(1'b1, OFS_IRQ_CLR, 32'h1);
    endtask
    task t_reset();
        rdchk("stat", OFS_STAT, 32'h0);
        check("enable", {29'h0, comp_enable}, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        check("route", {20'h0, inverting_route}, 32'h111);
    endtask
    task t_route();
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, OFS_CTRL1, 32'h8004 | i);
            rdchk("ctrl", OFS_CTRL1, 32'h8100 | i);
            check("route", {28'h0, inverting_route[0]}, 32'h1 << i);
        end
        check("enable", {29'h0, comp_enable}, 32'h1);
        rdchk("unmapped", 8'h1c, 32'h0);
    endtask
    // Comparators 2 and 3 under fall and any polarity; both are disabled again at the end
    // so that the idle scenario sees only comparator 1 in the status word.
    task t_more();
        xfer(1'b1, OFS_CTRL2, 32'h8080);
        rawk(1, 1'b1);
        rdchk("ctrl2", OFS_CTRL2, 32'h8380);
        xfer(1'b1, OFS_CTRL2, 32'h8080);
        rawk(1, 1'b0);
        rdchk("ctrl2", OFS_CTRL2, 32'h8280);
        xfer(1'b1, OFS_CTRL2, 32'h8080);
        rawk(1, 1'b1);
        rdchk("ctrl2", OFS_CTRL2, 32'h8180);
        xfer(1'b1, OFS_CTRL3, 32'h80c1);
        rawk(2, 1'b1);
        xfer(1'b1, OFS_CTRL3, 32'h80c1);
        rawk(2, 1'b0);
        rdchk("ctrl3", OFS_CTRL3, 32'h82c1);
        check("route3", {28'h0, inverting_route[2]}, 32'h2);
        check("enable", {29'h0, comp_enable}, 32'h7);
        rawk(2, 1'b1);
        rdchk("stat", OFS_STAT, 32'h406);
        rdchk("irq_stat", OFS_IRQ_STAT, 32'h6);
        irqchk(1'b0);
        xfer(1'b1, OFS_CTRL2, 32'h0);
        xfer(1'b1, OFS_CTRL3, 32'h0);
        rdchk("stat", OFS_STAT, 32'h0);
        xfer(1'b1, OFS_IRQ_CLR, 32'h6);
        rdchk("irq_stat", OFS_IRQ_STAT, 32'h0);
    endtask
    // A falling edge under rising polarity must still give the first event.
    task t_events();
        xfer(1'b1, OFS_CTRL1, 32'h8040);
        xfer(1'b1, OFS_IRQ_EN, 32'h1);
        rdchk("stat", OFS_STAT, 32'h1);
        raw(1'b0);
        rdchk("stat", OFS_STAT, 32'h100);
        irqchk(1'b1);
        clr();
        xfer(1'b1, OFS_STAT, 32'h0707);
        rdchk("stat", OFS_STAT, 32'h0);
        raw(1'b1);
        rdchk("stat", OFS_STAT, 32'h101);
        clr();
        raw(1'b0);
        rdchk("stat", OFS_STAT, 32'h0);
        irqchk(1'b0);
    endtask
    task t_idle();
        raw(1'b1);
        idle_mode <= 1'b1;
        irqchk(1'b1);
        xfer(1'b1, OFS_STAT, 32'h8000);
        irqchk(1'b0);
        rdchk("stat", OFS_STAT, 32'h8101);
        idle_mode <= 1'b0;
        irqchk(1'b1);
        xfer(1'b1, OFS_IRQ_EN, 32'h0);
        irqchk(1'b0);
        rdchk("irq_stat", OFS_IRQ_STAT, 32'h1);
        xfer(1'b1, OFS_IRQ_CLR, 32'h1);
        rdchk("irq_stat", OFS_IRQ_STAT, 32'h0);
    endtask
    task conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence: two reset cycles, then each scenario in turn.
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        comp_result_raw = 3'h1;
        idle_mode = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_route();
        t_events();
        t_more();
        t_idle();
        conclude();
    end
endmodule
`default_nettype wire
